// file: common/thps_defs.svh
/*
 * Constants of the touch host port: bus address, register indices of the
 * power-control byte and the sensing-control bytes, field positions, resets.
 * Assumes nothing; included by bare name wherever the numbers are needed.
 */
`ifndef THPS_DEFS_SVH
`define THPS_DEFS_SVH
// *****************************************************
// Bus address and register layout
// *****************************************************
`define THPS_DEV_ADDR      7'h28
`define THPS_IDX_CTRL      8'h00
`define THPS_IDX_ACT_EN    8'h21
`define THPS_IDX_ACT_SENS  8'h1F
`define THPS_IDX_ACT_AVG   8'h24
`define THPS_IDX_STB_EN    8'h40
`define THPS_IDX_STB_SENS  8'h42
`define THPS_IDX_STB_AVG   8'h41
`define THPS_IDX_TOUCH     8'h03
`define THPS_IDX_INT_EN    8'h27
`define THPS_BIT_DEEP_SLEEP_SELECT    4
`define THPS_BIT_STANDBY_SELECT      5
`define THPS_RST_CTRL      8'h00
`define THPS_RST_ACT_EN    8'hFF
`define THPS_RST_STB_EN    8'h01
`define THPS_RST_SENS      8'h2F
`define THPS_RST_AVG       8'h39
`define THPS_RST_INT_EN    8'hFF
`define THPS_MEM_DEPTH     256
`endif

// file: common/thps_pkg.sv
/*
 * Types shared by the touch host port modules.
 * Assumes thps_defs.svh for the numbers.
 */
package thps_pkg;
  typedef enum logic [1:0] {
    THPS_PWR_ACTIVE  = 2'b00,
    THPS_PWR_STANDBY = 2'b01,
    THPS_PWR_DEEP    = 2'b10
  } thps_pwr_t;

  typedef enum logic [2:0] {
    THPS_ST_IDLE  = 3'b000,
    THPS_ST_ADDR  = 3'b001,
    THPS_ST_AACK  = 3'b010,
    THPS_ST_WRX   = 3'b011,
    THPS_ST_WACK  = 3'b100,
    THPS_ST_RTX   = 3'b101,
    THPS_ST_RACK  = 3'b110
  } thps_st_t;
endpackage : thps_pkg

// file: common/thps_mem_if.sv
/*
 * Register-file port between the bus engine and its byte memory.
 * Assumes one clock shared by both ends.
 */
interface thps_mem_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport engine (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem    (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : thps_mem_if

// file: logic/thps_mem.sv
/*
 * 256-byte register memory with registered read data.
 * Assumes the engine holds raddr stable a cycle before it uses rdata.
 */
`include "thps_defs.svh"
module thps_mem (
  input  wire logic   i_sys_clk,
  thps_mem_if.mem     port
);
  logic [7:0] bytes [0:`THPS_MEM_DEPTH-1];

  always_ff @(posedge i_sys_clk) begin
    if (port.we) begin
      bytes[port.waddr] <= port.wdata;
    end
    port.rdata <= bytes[port.raddr];
  end
endmodule : thps_mem

// file: logic/thps_port.sv
/*
 * Serial client port of an eight-input touch controller with the power-state
 * control that the port's writes steer. Block read and block write with a
 * wrapping register pointer; power state and sensing-control selection.
 * Assumes bus pins are already synchronous to i_sys_clk and slow versus it.
 */
// Summary of operation
// R1: Write index, repeated start, then read bytes
// R2: Read pointer increments per byte, wraps
// R3: Write index then data into consecutive registers
// R4: Write pointer increments per stored byte, wraps
// R5: Host acks all but last read byte
// R6: Device acks every received byte
// R7: Stop resets client interface state
// R8: Power state from standby and deep-sleep bits
// R9: State change clears touch status
// R10: Active scans active-enabled inputs only
// R11: Standby scans standby inputs, interrupts continue
// R12: Standby serves bus; clear bit returns Active
// R13: Deep sleep stops all scanning
// R14: Bus traffic wakes temporarily, bit stays set
// R15: Clearing deep-sleep bit resumes Active (code: resumes Standby instead while the standby bit is set)
// R16: Poll results or interrupt on touch
// R17: Sensing controls chosen by power state
// R18: Power bits act after acked byte (code: acts at the clock fall ending the eighth data bit, before the ack bit)
`include "thps_defs.svh"
module thps_port
  import thps_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe_n,
  input  wire logic [7:0] i_touch_raw,
  output logic [7:0]      o_scan_enable,
  output logic [7:0]      o_sensitivity,
  output logic [7:0]      o_averaging,
  output logic [1:0]      o_power_state,
  output logic            o_awake,
  output logic [7:0]      o_touch_status,
  output logic            o_alert_n
);
  // *****************************************************
  // State
  // *****************************************************
  typedef struct packed {
    logic       scl_d;
    logic       sda_d;
    thps_st_t   st;
    logic [2:0] bitc;
    logic       armed;
    logic [7:0] sh;
    logic       rd;
    logic       idx_phase;
    logic       busy;
    logic       sda_low;
    logic [7:0] ptr;
    logic [7:0] ctrl;
    logic [7:0] act_en;
    logic [7:0] act_sens;
    logic [7:0] act_avg;
    logic [7:0] stb_en;
    logic [7:0] stb_sens;
    logic [7:0] stb_avg;
    logic [7:0] int_en;
    logic [7:0] touch;
    thps_pwr_t  pwr;
  } thps_state_t;

  thps_state_t s;
  thps_state_t next_s;
  thps_mem_if  mif ();

  thps_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .port      (mif.mem)
  );

  function automatic logic [7:0] inc_wrap(input logic [7:0] p);
    inc_wrap = p + 8'h01;
  endfunction : inc_wrap

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = i_scl & ~s.scl_d;
  assign scl_fall = ~i_scl & s.scl_d;
  assign start_c  = i_scl & s.scl_d & s.sda_d & ~i_sda;
  assign stop_c   = i_scl & s.scl_d & ~s.sda_d & i_sda;

  // *****************************************************
  // Next state
  // *****************************************************
  thps_pwr_t pwr_sel;
  logic [7:0] wbyte;

  always_comb begin
    next_s = s;
    next_s.scl_d = i_scl;
    next_s.sda_d = i_sda;
    mif.we    = 1'b0;
    mif.waddr = s.ptr;
    mif.wdata = s.sh;
    mif.raddr = s.ptr;
    wbyte = s.sh;
    if (start_c) begin
      next_s.st = THPS_ST_ADDR;
      next_s.bitc = 3'h0;
      // Bits of a cut byte before a repeated start must not pass for an address
      next_s.sh = 8'h00;
      next_s.armed = 1'b0;
      next_s.sda_low = 1'b0;
    end else if (stop_c) begin
      next_s.st = THPS_ST_IDLE; // R7
      next_s.busy = 1'b0; // R14
      next_s.sda_low = 1'b0;
    end else begin
      unique case (s.st)
        THPS_ST_IDLE: begin
        end
        THPS_ST_ADDR, THPS_ST_WRX: begin
          if (scl_rise) begin
            next_s.sh = {s.sh[6:0], i_sda};
            next_s.bitc = s.bitc + 3'h1;
            next_s.armed = 1'b1;
          end
          // The fall right after a start carries no bit, so a byte ends only after a rise
          if (scl_fall && s.bitc == 3'h0 && (s.armed || s.st == THPS_ST_WRX)) begin
            if (s.st == THPS_ST_ADDR) begin
              if (s.sh[7:1] == `THPS_DEV_ADDR) begin
                next_s.st = THPS_ST_AACK;
                next_s.sda_low = 1'b1; // R6
                next_s.rd = s.sh[0];
                next_s.busy = 1'b1; // R14
                next_s.idx_phase = ~s.sh[0]; // R1
              end else begin
                next_s.st = THPS_ST_IDLE;
              end
            end else begin
              next_s.st = THPS_ST_WACK;
              next_s.sda_low = 1'b1; // R6
              if (s.idx_phase) begin
                next_s.ptr = s.sh; // R1 R3
                next_s.idx_phase = 1'b0;
              end else begin
                mif.we = 1'b1; // R3
                next_s.ptr = inc_wrap(s.ptr); // R4
                if (s.ptr == `THPS_IDX_CTRL) next_s.ctrl = wbyte; // R18
                if (s.ptr == `THPS_IDX_ACT_EN) next_s.act_en = wbyte;
                if (s.ptr == `THPS_IDX_ACT_SENS) next_s.act_sens = wbyte;
                if (s.ptr == `THPS_IDX_ACT_AVG) next_s.act_avg = wbyte;
                if (s.ptr == `THPS_IDX_STB_EN) next_s.stb_en = wbyte;
                if (s.ptr == `THPS_IDX_STB_SENS) next_s.stb_sens = wbyte;
                if (s.ptr == `THPS_IDX_STB_AVG) next_s.stb_avg = wbyte;
                if (s.ptr == `THPS_IDX_INT_EN) next_s.int_en = wbyte;
              end
            end
          end
        end
        THPS_ST_AACK, THPS_ST_WACK: begin
          if (scl_fall) begin
            next_s.bitc = 3'h0;
            next_s.sh = 8'h00;
            if (s.st == THPS_ST_AACK && s.rd) begin
              next_s.st = THPS_ST_RTX;
              next_s.sh = (s.ptr == `THPS_IDX_TOUCH) ? s.touch : mif.rdata; // R1
              next_s.sda_low = ~((s.ptr == `THPS_IDX_TOUCH) ? s.touch[7] : mif.rdata[7]);
              next_s.ptr = inc_wrap(s.ptr); // R2
            end else begin
              next_s.st = THPS_ST_WRX;
              next_s.sda_low = 1'b0;
            end
          end
        end
        THPS_ST_RTX: begin
          if (scl_fall) begin
            next_s.bitc = s.bitc + 3'h1;
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.sda_low = ~s.sh[6];
            if (s.bitc == 3'h7) begin
              next_s.st = THPS_ST_RACK;
              next_s.sda_low = 1'b0;
            end
          end
        end
        THPS_ST_RACK: begin
          if (scl_rise) begin
            next_s.st = i_sda ? THPS_ST_IDLE : THPS_ST_AACK; // R5
            next_s.rd = 1'b1;
          end
        end
        default: next_s.st = THPS_ST_IDLE;
      endcase
    end
    // Keeps the byte-boundary check simple: bitc wraps to zero after eight bits
    // Power state from the two select bits, deep sleep taking priority
    if (next_s.ctrl[`THPS_BIT_DEEP_SLEEP_SELECT]) pwr_sel = THPS_PWR_DEEP; // R8 R13 R15
    else if (next_s.ctrl[`THPS_BIT_STANDBY_SELECT]) pwr_sel = THPS_PWR_STANDBY; // R11 R12
    else pwr_sel = THPS_PWR_ACTIVE;
    next_s.pwr = pwr_sel;
    if (pwr_sel != s.pwr) begin
      next_s.touch = 8'h00; // R9
    end else begin
      next_s.touch = s.touch | (i_touch_raw & o_scan_enable);
    end
    if (s.st == THPS_ST_RTX && s.ptr == inc_wrap(`THPS_IDX_TOUCH) && s.bitc == 3'h0 && scl_fall) begin
      next_s.touch = i_touch_raw & o_scan_enable; // Read clears latched touches
    end
  end

  // *****************************************************
  // Registers and outputs
  // *****************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{scl_d: 1'b1, sda_d: 1'b1, st: THPS_ST_IDLE, bitc: 3'h0, armed: 1'b0, sh: 8'h00, rd: 1'b0,
             idx_phase: 1'b0, busy: 1'b0, sda_low: 1'b0, ptr: 8'h00,
             ctrl: `THPS_RST_CTRL, act_en: `THPS_RST_ACT_EN, act_sens: `THPS_RST_SENS,
             act_avg: `THPS_RST_AVG, stb_en: `THPS_RST_STB_EN, stb_sens: `THPS_RST_SENS,
             stb_avg: `THPS_RST_AVG, int_en: `THPS_RST_INT_EN, touch: 8'h00,
             pwr: THPS_PWR_ACTIVE};
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    unique case (s.pwr)
      THPS_PWR_ACTIVE: begin
        o_scan_enable = s.act_en; // R10 R17
        o_sensitivity = s.act_sens;
        o_averaging   = s.act_avg;
      end
      THPS_PWR_STANDBY: begin
        o_scan_enable = s.stb_en; // R11 R17
        o_sensitivity = s.stb_sens;
        o_averaging   = s.stb_avg;
      end
      default: begin
        o_scan_enable = 8'h00; // R13
        o_sensitivity = s.act_sens;
        o_averaging   = s.act_avg;
      end
    endcase
  end

  assign o_sda_oe_n     = ~s.sda_low;
  assign o_power_state  = s.pwr;
  assign o_awake        = (s.pwr != THPS_PWR_DEEP) | s.busy; // R14
  assign o_touch_status = s.touch;
  assign o_alert_n      = ~|(s.touch & s.int_en); // R16 R11
endmodule : thps_port

// file: verification/thps_port_props.sv
/*
 * Pin checker of thps_port.
 * Assumes bus pins synchronous to i_sys_clk.
 */
module thps_props (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_oe_n,
  input wire logic [7:0] i_touch_raw,
  input wire logic [7:0] o_scan_enable,
  input wire logic [1:0] o_power_state,
  input wire logic       o_awake,
  input wire logic [7:0] o_touch_status,
  input wire logic       o_alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Relations
  // ********
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  property p_legal; o_power_state != 2'h3; endproperty
  a_legal: assert property (p_legal) else $error("bad state");
  property p_scan; o_power_state == 2'h2 |-> o_scan_enable == 8'h00; endproperty
  a_scan: assert property (p_scan) else $error("scan in sleep");
  property p_awake; o_power_state != 2'h2 |-> o_awake; endproperty
  a_awake: assert property (p_awake) else $error("not awake");
  property p_resleep; i_scl && $past(i_scl) && $rose(i_sda) && o_power_state == 2'h2 |-> ##[1:8] !o_awake; endproperty
  a_resleep: assert property (p_resleep) else $error("no resleep");
  property p_hold; i_scl && $past(i_scl) |-> $stable(o_sda_oe_n); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_ack; $fell(o_sda_oe_n) |-> (!o_sda_oe_n) [*8]; endproperty
  a_ack: assert property (p_ack) else $error("short pull");
  property p_clear; $changed(o_power_state) && i_touch_raw == 8'h00 |-> ##[0:1] o_touch_status == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("touch kept");
  property p_alert; (o_touch_status == 8'h00) [*2] |-> o_alert_n; endproperty
  a_alert: assert property (p_alert) else $error("stray alert");
  c_sleep: cover property (o_power_state == 2'h2 && !o_awake);
  c_standby_select: cover property (o_power_state == 2'h1);
  c_touch: cover property (!o_alert_n);
endmodule : thps_props

bind thps_port thps_props u_props (.i_sys_clk, .i_rst, .i_scl, .i_sda, .o_sda_oe_n, .i_touch_raw,
  .o_scan_enable, .o_power_state, .o_awake, .o_touch_status, .o_alert_n);

// file: verification/thps_host_model.sv
/*
 * Bus host model: start, stop, byte transfer.
 * Assumes a pulled-up data line fed back on i_sda_line.
 */
module thps_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bus phases
  // ********
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Eight clocks a phase keeps the port's sampling well inside each level
  task automatic step(input logic c, input logic d);
    o_scl <= c;
    o_sda <= d;
    repeat (8) @(posedge i_sys_clk);
  endtask : step
  // Also serves as repeated start from clock low
  task automatic start;
    step(o_scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic bit_io(input logic d, output logic q);
    step(1'b0, d);
    step(1'b1, d);
    q = i_sda_line;
    step(1'b0, d);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : thps_host_model

// file: verification/touch_host_port_power_states_tb_top.sv
/*
 * Self-checking bench of thps_port.
 * Assumes defs, package, design and host model compiled first.
 */
`include "thps_defs.svh"
module touch_host_port_power_states_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_sys_clk, i_rst, scl, sda_host, oe_n, awake, alert_n, ack;
  logic [7:0] touch_raw, scan, tstat, q, sens, avg;
  logic [1:0] pwr;
  int         err_count, compares;
  // Pulled-up line: low when either side pulls
  wire        sda = sda_host & oe_n;
  thps_port u_dut (.i_sys_clk, .i_rst, .i_scl(scl), .i_sda(sda), .o_sda_oe_n(oe_n),
    .i_touch_raw(touch_raw), .o_scan_enable(scan), .o_sensitivity(sens), .o_averaging(avg),
    .o_power_state(pwr), .o_awake(awake), .o_touch_status(tstat), .o_alert_n(alert_n));
  thps_host_model u_host (.i_sys_clk, .i_sda_line(sda), .o_scl(scl), .o_sda(sda_host));
  // ********
  // Helpers
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic put(input logic [7:0] d);
    u_host.xfer(d, 1'b1, q, ack);
    chk(ack, 8'h00);
  endtask : put
  task automatic open_wr(input logic [7:0] idx);
    u_host.start();
    put({`THPS_DEV_ADDR, 1'b0});
    put(idx);
  endtask : open_wr
  task automatic get(input logic last, input logic [7:0] exp);
    u_host.xfer(8'hFF, last, q, ack);
    chk(q, exp);
  endtask : get
  // ********
  // Scenarios
  // ********
  task automatic t_wrap;
    open_wr(8'hFE);
    put(8'hA5);
    put(8'h5A);
    put(8'h00);
    u_host.stop();
    open_wr(8'hFE);
    u_host.start();
    put({`THPS_DEV_ADDR, 1'b1});
    get(1'b0, 8'hA5);
    get(1'b0, 8'h5A);
    get(1'b1, 8'h00);
    u_host.stop();
  endtask : t_wrap
  task automatic t_refuse;
    u_host.start();
    u_host.xfer({7'h29, 1'b0}, 1'b1, q, ack);
    chk(ack, 8'h01);
    u_host.stop();
  endtask : t_refuse
  task automatic t_power;
    open_wr(`THPS_IDX_STB_EN);
    put(8'h03);
    put(8'h1C);
    put(8'h6A);
    u_host.stop();
    open_wr(`THPS_IDX_CTRL);
    put(8'h20);
    chk(pwr, 8'h01);
    chk(scan, 8'h03);
    chk(sens, 8'h6A);
    chk(avg, 8'h1C);
    u_host.stop();
    open_wr(`THPS_IDX_CTRL);
    put(8'h30);
    chk(pwr, 8'h02);
    chk(awake, 8'h01);
    u_host.stop();
    chk(awake, 8'h00);
    chk(scan, 8'h00);
  endtask : t_power
  task automatic t_deep;
    open_wr(`THPS_IDX_CTRL);
    chk(awake, 8'h01);
    chk(pwr, 8'h02);
    put(8'h00);
    u_host.stop();
    chk(pwr, 8'h00);
    chk(awake, 8'h01);
    chk(scan, `THPS_RST_ACT_EN);
    chk(sens, `THPS_RST_SENS);
    chk(avg, `THPS_RST_AVG);
  endtask : t_deep
  task automatic t_touch;
    touch_raw <= 8'h04;
    repeat (4) @(posedge i_sys_clk);
    touch_raw <= 8'h00;
    repeat (4) @(posedge i_sys_clk);
    chk(tstat, 8'h04);
    chk(alert_n, 8'h00);
    open_wr(`THPS_IDX_TOUCH);
    u_host.start();
    put({`THPS_DEV_ADDR, 1'b1});
    get(1'b1, 8'h04);
    u_host.stop();
    chk(tstat, 8'h00);
    chk(alert_n, 8'h01);
    touch_raw <= 8'h04;
    repeat (4) @(posedge i_sys_clk);
    touch_raw <= 8'h00;
    repeat (4) @(posedge i_sys_clk);
    chk(tstat, 8'h04);
    open_wr(`THPS_IDX_CTRL);
    put(8'h20);
    u_host.stop();
    chk(tstat, 8'h00);
    chk(alert_n, 8'h01);
  endtask : t_touch
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    err_count++;
    summarize();
  end
  initial begin
    i_rst = 1'b1;
    touch_raw = 8'h00;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    t_wrap();
    t_refuse();
    t_power();
    t_deep();
    t_touch();
    summarize();
  end
endmodule : touch_host_port_power_states_tb_top
